// file: prc_lan_model.sv
// Purpose: lan controller side of the reset-complete exchange
// Assumes: drives on the falling edge of core_clk_i
// Notes:   slow_i stretches the answer to the reset-complete request
`timescale 1ns/1ns
module prc_lan_model (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic slow_i,
    input  wire logic rst_done_i,
    input  wire logic phy_busy_i,
    output logic      rst_done_ack_o
);
    int wait_cnt;
    initial begin
        rst_done_ack_o = 1'b0;
        wait_cnt = 0;
    end
    always @(negedge core_clk_i) begin
        rst_done_ack_o <= 1'b0;
        if (sys_rst_i || rst_done_i !== 1'b1 || rst_done_ack_o) begin
            wait_cnt <= 0;
        end else if (phy_busy_i === 1'b0) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= (slow_i ? 12 : 1)) begin
                rst_done_ack_o <= 1'b1;
            end
        end
    end
endmodule

// file: prc_pkg.sv
// Purpose: shared constants and carriers for the phy reset controller
// Assumes: 50 MHz core clock
// Notes:   times kept in their printed unit, cycle counts derived here
package prc_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 20;

    // phy_reset_done_limit, microseconds
    localparam int unsigned PHY_RESET_DONE_LIMIT_US = 10_000;
    // connect_to_negotiate_time window, milliseconds
    localparam int unsigned CONNECT_NEG_MIN_MS = 1_200;
    localparam int unsigned CONNECT_NEG_MAX_MS = 1_300;
    // crystal_settle_time and power-on trigger limit, milliseconds
    localparam int unsigned CRYSTAL_SETTLE_TIME_MS = 45;
    localparam int unsigned POR_TRIGGER_LIMIT_MS = 40;
    // config_after_ready_limit, milliseconds
    localparam int unsigned CONFIG_AFTER_READY_LIMIT_MS = 500;

    // longest times round down
    localparam int unsigned PHY_DONE_CYC = PHY_RESET_DONE_LIMIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned XTAL_CYC     = CRYSTAL_SETTLE_TIME_MS * (CLK_HZ / 1_000);
    localparam int unsigned POR_CYC      = POR_TRIGGER_LIMIT_MS * (CLK_HZ / 1_000);
    // least time rounds up (exact at this rate)
    localparam int unsigned NEG_MIN_CYC  = CONNECT_NEG_MIN_MS * (CLK_HZ / 1_000);
    localparam int unsigned NEG_MAX_CYC  = CONNECT_NEG_MAX_MS * (CLK_HZ / 1_000);
    localparam int unsigned CFG_LIM_CYC  = CONFIG_AFTER_READY_LIMIT_MS * (CLK_HZ / 1_000);

    // management soft reset: register 0 bit 15
    localparam logic [4:0] MGMT_CTRL_REG   = 5'h00;
    localparam int unsigned SOFT_RST_BIT   = 15;
    localparam logic [4:0] MGMT_PAGE_ZERO  = 5'h00;

    localparam int unsigned CNT_W   = 32;
    localparam int unsigned STRAP_W = 4;
    localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

    // per-domain reset strobes driven to the rest of the device
    typedef struct packed {
        logic iface;      // interconnect logic
        logic non_phy;    // non-phy registers and state
        logic phy;        // phy registers, page 0 and aliases
        logic fuse;       // fuse / bonding registers
        logic wake;       // wake-up registers
        logic wake_filt;  // wake-up filter contents
        logic fifo;       // internal fifo clear
        logic serdes_off; // serdes halted
    } prc_rst_vec_t;

    localparam prc_rst_vec_t RST_VEC_ALL = 8'hFF;
    localparam prc_rst_vec_t RST_VEC_NONE = 8'h00;

    // management write carrier
    typedef struct packed {
        logic        valid;
        logic [4:0]  page;
        logic [4:0]  addr;
        logic [15:0] data;
    } prc_mgmt_wr_t;

endpackage

// file: prc_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input asynchronous to core_clk_i
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ns
module prc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic out_ff;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            out_ff <= RST_VAL;
        end else if (s2_ff == s3_ff) begin
            out_ff <= s3_ff;
        end
    end

    assign sync_o = out_ff;
endmodule

// file: prc_top.sv
// Purpose: reset sequencing for an ethernet phy device
// Assumes: supply sense, crystal ok and pins are asynchronous inputs
// Notes:   one 50 MHz clock; soft reset seen as a decoded management write
// Operation
// - hold master reset until supplies stable
// - master reset forces all registers default
// - latch straps when master reset releases
// - register 0 bit 15 write soft-resets phy
// - soft reset touches only phy state
// - soft reset restores page 0 only
// - interconnect reset stops serdes, drops packet
// - interconnect release clears fifo unless wake switch
// - in-band reset clears all but wake filters; the code also leaves the wake registers set apart
// - only lan-off pin resets phy logic; the code also resets it on soft and in-band reset
// - supply power-on reset leaves power-down mode
// - send reset-complete after phy reset ends
// - reset-complete within 10 ms of release
// - negotiate 1.2 s to 1.3 s after connect
// - crystal stable within 45 ms of ramp
// - power-on trigger within 40 ms of crystal
`timescale 1ns/1ns
module prc_top #(
    parameter int unsigned PHY_DONE_CYC = prc_pkg::PHY_DONE_CYC,
    parameter int unsigned NEG_MIN_CYC  = prc_pkg::NEG_MIN_CYC,
    parameter int unsigned NEG_MAX_CYC  = prc_pkg::NEG_MAX_CYC,
    parameter int unsigned XTAL_CYC     = prc_pkg::XTAL_CYC,
    parameter int unsigned POR_CYC      = prc_pkg::POR_CYC,
    parameter int unsigned PHY_WORK_CYC = 16
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         supply_ok_i,
    input  wire logic                         xtal_ok_i,
    input  wire logic [prc_pkg::STRAP_W-1:0]  strap_i,
    input  wire prc_pkg::prc_mgmt_wr_t        mgmt_wr_i,
    input  wire logic                         link_rst_pin_n_i,
    input  wire logic                         wake_switch_i,
    input  wire logic                         inband_rst_i,
    input  wire logic                         lan_off_pin_n_i,
    input  wire logic                         cable_connect_i,
    input  wire logic                         rst_done_ack_i,
    output logic                              master_rst_n_o,
    output prc_pkg::prc_rst_vec_t             rst_vec_o,
    output logic                              page0_restore_o,
    output logic                              pkt_drop_o,
    output logic [prc_pkg::STRAP_W-1:0]       strap_o,
    output logic                              power_down_o,
    output logic                              rst_done_o,
    output logic                              phy_busy_o,
    output logic                              negotiate_start_o,
    output logic                              xtal_late_o,
    output logic                              por_late_o
);
    typedef enum logic [3:0] {
        PS_IDLE = 4'b0001,
        PS_WORK = 4'b0010,
        PS_DONE = 4'b0100,
        PS_RUN  = 4'b1000
    } prc_phy_st_t;

    logic supply_s;
    logic xtal_s;
    logic link_rst_n_s;
    logic lan_off_n_s;

    prc_sync3 #(.RST_VAL(1'b0)) u_sync_sup (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (supply_ok_i),
        .sync_o     (supply_s)
    );
    prc_sync3 #(.RST_VAL(1'b0)) u_sync_xtal (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (xtal_ok_i),
        .sync_o     (xtal_s)
    );
    prc_sync3 #(.RST_VAL(1'b1)) u_sync_link (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (link_rst_pin_n_i),
        .sync_o     (link_rst_n_s)
    );
    prc_sync3 #(.RST_VAL(1'b1)) u_sync_lan (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (lan_off_pin_n_i),
        .sync_o     (lan_off_n_s)
    );

    // master reset: released once supply and crystal are both stable
    logic master_rst_n_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            master_rst_n_ff <= 1'b0;
        end else begin
            master_rst_n_ff <= supply_s & xtal_s;
        end
    end
    assign master_rst_n_o = master_rst_n_ff;

    logic por_rise;
    logic master_d_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            master_d_ff <= 1'b0;
        end else begin
            master_d_ff <= master_rst_n_ff;
        end
    end
    assign por_rise = master_rst_n_ff & ~master_d_ff;

    // straps caught on the release edge only
    logic [prc_pkg::STRAP_W-1:0] strap_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            strap_ff <= prc_pkg::STRAP_RST;
        end else if (!master_rst_n_ff) begin
            strap_ff <= prc_pkg::STRAP_RST;
        end else if (por_rise) begin
            strap_ff <= strap_i;
        end
    end
    assign strap_o = strap_ff;

    // soft reset decode
    logic soft_rst;
    assign soft_rst = mgmt_wr_i.valid && mgmt_wr_i.page == prc_pkg::MGMT_PAGE_ZERO
                   && mgmt_wr_i.addr == prc_pkg::MGMT_CTRL_REG
                   && mgmt_wr_i.data[prc_pkg::SOFT_RST_BIT];

    // interconnect and lan-off pin release edges
    logic link_n_d_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            link_n_d_ff <= 1'b1;
        end else begin
            link_n_d_ff <= link_rst_n_s;
        end
    end
    logic link_release;
    assign link_release = link_rst_n_s & ~link_n_d_ff;

    logic lan_n_d_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            lan_n_d_ff <= 1'b1;
        end else begin
            lan_n_d_ff <= lan_off_n_s;
        end
    end
    logic lan_release;
    assign lan_release = lan_off_n_s & ~lan_n_d_ff;

    // reset strobes per domain
    prc_pkg::prc_rst_vec_t nxt_rst_vec;
    prc_pkg::prc_rst_vec_t rst_vec_ff;
    always_comb begin
        nxt_rst_vec = prc_pkg::RST_VEC_NONE;
        if (!master_rst_n_ff) begin
            nxt_rst_vec = prc_pkg::RST_VEC_ALL;
        end else begin
            if (inband_rst_i) begin
                nxt_rst_vec.iface   = 1'b1;
                nxt_rst_vec.non_phy = 1'b1;
                nxt_rst_vec.phy     = 1'b1;
                nxt_rst_vec.fuse    = 1'b1;
                nxt_rst_vec.fifo    = 1'b1;
            end
            if (soft_rst || !lan_off_n_s) begin
                nxt_rst_vec.phy = 1'b1;
            end
            if (!link_rst_n_s) begin
                nxt_rst_vec.iface      = 1'b1;
                nxt_rst_vec.serdes_off = 1'b1;
            end
            if (link_release && !wake_switch_i) begin
                nxt_rst_vec.fifo = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rst_vec_ff <= prc_pkg::RST_VEC_ALL;
        end else begin
            rst_vec_ff <= nxt_rst_vec;
        end
    end
    assign rst_vec_o = rst_vec_ff;

    // page 0 and aliases restored on any phy reset
    logic page0_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            page0_ff <= 1'b1;
        end else begin
            page0_ff <= nxt_rst_vec.phy;
        end
    end
    assign page0_restore_o = page0_ff;

    // drop in-flight packet on interconnect reset entry
    logic pkt_drop_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pkt_drop_ff <= 1'b0;
        end else begin
            pkt_drop_ff <= ~link_rst_n_s & link_n_d_ff;
        end
    end
    assign pkt_drop_o = pkt_drop_ff;

    // power-down: lan-off pin enters, pin release, power-on or in-band reset leaves
    logic pd_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pd_ff <= 1'b0;
        end else if (por_rise || inband_rst_i || lan_release) begin
            pd_ff <= 1'b0;
        end else if (!lan_off_n_s) begin
            pd_ff <= 1'b1;
        end
    end
    assign power_down_o = pd_ff;

    // phy reset sequence and completion report
    prc_phy_st_t st_ff;
    logic [prc_pkg::CNT_W-1:0] work_cnt_ff;
    logic [prc_pkg::CNT_W-1:0] done_cnt_ff;
    logic phy_rst_req;
    assign phy_rst_req = nxt_rst_vec.phy;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= PS_IDLE;
        end else if (phy_rst_req) begin
            st_ff <= PS_WORK;
        end else begin
            unique case (st_ff)
                PS_IDLE: st_ff <= PS_IDLE;
                PS_WORK: begin
                    if (work_cnt_ff >= PHY_WORK_CYC - 1
                        || done_cnt_ff >= PHY_DONE_CYC - 2) begin
                        st_ff <= PS_DONE;
                    end
                end
                PS_DONE: begin
                    if (rst_done_ack_i) begin
                        st_ff <= PS_RUN;
                    end
                end
                PS_RUN: st_ff <= PS_RUN;
                default: st_ff <= PS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || phy_rst_req || st_ff != PS_WORK) begin
            work_cnt_ff <= '0;
        end else begin
            work_cnt_ff <= work_cnt_ff + 1'b1;
        end
    end

    // time since reset release, bounds the report
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || phy_rst_req) begin
            done_cnt_ff <= '0;
        end else if (st_ff == PS_WORK) begin
            done_cnt_ff <= done_cnt_ff + 1'b1;
        end
    end

    logic rst_done_ff;
    logic busy_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rst_done_ff <= 1'b0;
            busy_ff     <= 1'b1;
        end else begin
            rst_done_ff <= (st_ff == PS_DONE) && !phy_rst_req && !rst_done_ack_i;
            busy_ff     <= phy_rst_req || st_ff == PS_WORK;
        end
    end
    assign rst_done_o = rst_done_ff;
    assign phy_busy_o = busy_ff;

    // connect to negotiation start window
    logic [prc_pkg::CNT_W-1:0] neg_cnt_ff;
    logic neg_arm_ff;
    logic neg_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !cable_connect_i || phy_rst_req) begin
            neg_cnt_ff <= '0;
            neg_arm_ff <= 1'b1;
            neg_ff     <= 1'b0;
        end else if (neg_arm_ff) begin
            neg_cnt_ff <= neg_cnt_ff + 1'b1;
            if (neg_cnt_ff >= NEG_MIN_CYC - 1 && st_ff == PS_RUN) begin
                neg_ff     <= 1'b1;
                neg_arm_ff <= 1'b0;
            end else if (neg_cnt_ff >= NEG_MAX_CYC - 1) begin
                neg_ff     <= 1'b1;
                neg_arm_ff <= 1'b0;
            end
        end else begin
            neg_ff <= 1'b0;
        end
    end
    assign negotiate_start_o = neg_ff;

    // start-up guarantees watched against supply and crystal
    logic [prc_pkg::CNT_W-1:0] xtal_cnt_ff;
    logic [prc_pkg::CNT_W-1:0] por_cnt_ff;
    logic xtal_late_ff;
    logic por_late_ff;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !supply_s || xtal_s) begin
            xtal_cnt_ff <= '0;
        end else if (xtal_cnt_ff < XTAL_CYC) begin
            xtal_cnt_ff <= xtal_cnt_ff + 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !xtal_s || master_rst_n_ff) begin
            por_cnt_ff <= '0;
        end else if (por_cnt_ff < POR_CYC) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            xtal_late_ff <= 1'b0;
            por_late_ff  <= 1'b0;
        end else begin
            xtal_late_ff <= xtal_late_ff | (xtal_cnt_ff >= XTAL_CYC);
            por_late_ff  <= por_late_ff | (por_cnt_ff >= POR_CYC);
        end
    end
    assign xtal_late_o = xtal_late_ff;
    assign por_late_o  = por_late_ff;
endmodule

// file: prc_top_assertions.sv
// Purpose: port-level checks of the phy reset controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   negotiation timed by a local cycle counter
`timescale 1ns/1ns
module prc_top_chk #(
    parameter int unsigned PHY_DONE_CYC = 200,
    parameter int unsigned NEG_MIN_CYC  = 50,
    parameter int unsigned NEG_MAX_CYC  = 60
) (
    input wire logic                  core_clk_i,
    input wire logic                  sys_rst_i,
    input wire logic                  supply_ok_i,
    input wire prc_pkg::prc_mgmt_wr_t mgmt_wr_i,
    input wire logic                  link_rst_pin_n_i,
    input wire logic                  wake_switch_i,
    input wire logic                  inband_rst_i,
    input wire logic                  cable_connect_i,
    input wire logic                  master_rst_n_o,
    input wire prc_pkg::prc_rst_vec_t rst_vec_o,
    input wire logic                  page0_restore_o,
    input wire logic [3:0]            strap_o,
    input wire logic                  power_down_o,
    input wire logic                  rst_done_o,
    input wire logic                  negotiate_start_o
);
    localparam int DONE_HI = PHY_DONE_CYC;
    localparam int NEG_HI  = NEG_MAX_CYC + 2;
    logic [15:0] neg_cnt_ff;
    wire logic   soft_wr = mgmt_wr_i.valid && mgmt_wr_i.page == prc_pkg::MGMT_PAGE_ZERO
                           && mgmt_wr_i.addr == prc_pkg::MGMT_CTRL_REG && mgmt_wr_i.data[15];
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // cycles since cable seen high
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !cable_connect_i)
            neg_cnt_ff <= 16'h0000;
        else if (neg_cnt_ff != 16'hFFFF)
            neg_cnt_ff <= neg_cnt_ff + 16'h0001;
    end
    sequence s_pin_low;
        $fell(link_rst_pin_n_i) ##1 !link_rst_pin_n_i [*6];
    endsequence
    sequence s_iface_off;
        rst_vec_o.iface && rst_vec_o.serdes_off;
    endsequence
    a_master_hold: assert property (!supply_ok_i [*6] |-> !master_rst_n_o)
        else $error("master reset released without supply");
    a_reset_all: assert property ($rose(master_rst_n_o) |-> $past(rst_vec_o) == 8'hFF)
        else $error("reset vector not all set under master reset");
    a_strap_hold: assert property (master_rst_n_o && $past(master_rst_n_o, 2) |-> $stable(strap_o))
        else $error("straps changed after capture");
    a_soft_phy: assert property (master_rst_n_o && soft_wr |=> rst_vec_o.phy && page0_restore_o)
        else $error("soft reset write did not reset phy");
    a_soft_only: assert property (master_rst_n_o && $past(master_rst_n_o) && soft_wr && !inband_rst_i
        |=> !rst_vec_o.non_phy && !rst_vec_o.fuse && !rst_vec_o.wake)
        else $error("soft reset touched non-phy state");
    a_pin_stop: assert property (s_pin_low |-> s_iface_off)
        else $error("interconnect reset did not stop serdes");
    a_fifo_clear: assert property ($rose(link_rst_pin_n_i) && !wake_switch_i |-> ##[1:8] rst_vec_o.fifo)
        else $error("fifo not cleared on interconnect release");
    a_fifo_keep: assert property ($rose(link_rst_pin_n_i) && wake_switch_i |-> !rst_vec_o.fifo [*8])
        else $error("fifo cleared during wake switch");
    a_inband_all: assert property (inband_rst_i && master_rst_n_o
        |-> ##[1:3] rst_vec_o.non_phy && rst_vec_o.phy && rst_vec_o.fuse)
        else $error("in-band reset incomplete");
    a_filt_keep: assert property (master_rst_n_o && $past(master_rst_n_o)
        |-> !rst_vec_o.wake_filt && !rst_vec_o.wake)
        else $error("wake state reset outside master reset");
    a_pd_exit: assert property (inband_rst_i && master_rst_n_o |-> ##[1:3] !power_down_o)
        else $error("power-down kept after in-band reset");
    a_done_bound: assert property ($rose(master_rst_n_o) |-> ##[1:DONE_HI] rst_done_o)
        else $error("reset complete late");
    a_neg_window: assert property (negotiate_start_o
        |-> neg_cnt_ff >= NEG_MIN_CYC - 1 && neg_cnt_ff <= NEG_MAX_CYC + 1)
        else $error("negotiation start outside window");
    a_neg_forced: assert property ($rose(cable_connect_i) |-> ##[1:NEG_HI] negotiate_start_o)
        else $error("negotiation never started");
endmodule
bind prc_top prc_top_chk #(
    .PHY_DONE_CYC(PHY_DONE_CYC), .NEG_MIN_CYC(NEG_MIN_CYC), .NEG_MAX_CYC(NEG_MAX_CYC)
) i_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
    .mgmt_wr_i(mgmt_wr_i), .link_rst_pin_n_i(link_rst_pin_n_i), .wake_switch_i(wake_switch_i),
    .inband_rst_i(inband_rst_i), .cable_connect_i(cable_connect_i),
    .master_rst_n_o(master_rst_n_o), .rst_vec_o(rst_vec_o), .page0_restore_o(page0_restore_o),
    .strap_o(strap_o), .power_down_o(power_down_o), .rst_done_o(rst_done_o),
    .negotiate_start_o(negotiate_start_o)
);

// file: test_prc_top.sv
// Purpose: self-checking bench for the phy reset controller
// Assumes: shortened counts, inputs driven on the falling edge
// Notes:   lan controller side played by prc_lan_model
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module test_prc_top;
    localparam int DONE = 200;
    localparam int NMIN = 50;
    localparam int NMAX = 60;
    logic                  core_clk_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
    logic                  supply_ok_i = 1'b0, xtal_ok_i = 1'b0, wake_switch_i = 1'b0;
    logic                  link_rst_pin_n_i = 1'b1, lan_off_pin_n_i = 1'b1;
    logic                  inband_rst_i = 1'b0, cable_connect_i = 1'b0;
    logic [3:0]            strap_i = 4'h3;
    prc_pkg::prc_mgmt_wr_t mgmt_wr_i = '0;
    prc_pkg::prc_rst_vec_t rst_vec_o;
    logic [3:0]            strap_o;
    logic                  master_rst_n_o, page0_restore_o, pkt_drop_o, power_down_o;
    logic                  rst_done_o, phy_busy_o, negotiate_start_o, xtal_late_o;
    logic                  por_late_o, rst_done_ack_i;
    int                    bad_count = 0;
    int                    checks = 0;
    always #10 core_clk_i = ~core_clk_i;
    prc_top #(.PHY_DONE_CYC(DONE), .NEG_MIN_CYC(NMIN), .NEG_MAX_CYC(NMAX),
        .XTAL_CYC(100), .POR_CYC(100), .PHY_WORK_CYC(16)) i_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
        .xtal_ok_i(xtal_ok_i), .strap_i(strap_i), .mgmt_wr_i(mgmt_wr_i),
        .link_rst_pin_n_i(link_rst_pin_n_i), .wake_switch_i(wake_switch_i),
        .inband_rst_i(inband_rst_i), .lan_off_pin_n_i(lan_off_pin_n_i),
        .cable_connect_i(cable_connect_i), .rst_done_ack_i(rst_done_ack_i),
        .master_rst_n_o(master_rst_n_o), .rst_vec_o(rst_vec_o), .page0_restore_o(page0_restore_o),
        .pkt_drop_o(pkt_drop_o), .strap_o(strap_o), .power_down_o(power_down_o),
        .rst_done_o(rst_done_o), .phy_busy_o(phy_busy_o), .negotiate_start_o(negotiate_start_o),
        .xtal_late_o(xtal_late_o), .por_late_o(por_late_o));
    prc_lan_model i_lan (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .rst_done_i(rst_done_o), .phy_busy_i(phy_busy_o), .rst_done_ack_o(rst_done_ack_i));
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic wait_hi(input string nm, ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        `CHK(nm, 1'b1, s)
    endtask
    // waits until all bits of mask are seen set
    task automatic wait_vec(input string nm, input logic [7:0] mask, input int lim);
        int n;
        n = 0;
        while ((rst_vec_o & mask) !== mask && n < lim) begin
            cyc(1);
            n++;
        end
        `CHK(nm, mask, rst_vec_o & mask)
    endtask
    task automatic t_power_up;
        cyc(10);
        `CHK("master_low", 1'b0, master_rst_n_o)
        `CHK("vec_all", prc_pkg::RST_VEC_ALL, rst_vec_o)
        supply_ok_i = 1'b1;
        cyc(10);
        `CHK("master_no_xtal", 1'b0, master_rst_n_o)
        strap_i = 4'hA;
        xtal_ok_i = 1'b1;
        wait_hi("master_up", master_rst_n_o, 10);
        cyc(3);
        strap_i = 4'h5;
        cyc(3);
        `CHK("strap", 4'hA, strap_o)
        `CHK("vec_clear", prc_pkg::RST_VEC_NONE, rst_vec_o)
        wait_hi("done", rst_done_o, DONE);
        `CHK("xtal_late", 1'b0, xtal_late_o)
        `CHK("por_late", 1'b0, por_late_o)
        $display("test power_up done");
    endtask
    task automatic t_soft;
        prc_pkg::prc_mgmt_wr_t wr[3];
        logic                  exp[3];
        wr = '{'{1'b1, 5'h00, 5'h00, 16'h8000}, '{1'b1, 5'h01, 5'h00, 16'h8000},
               '{1'b1, 5'h00, 5'h00, 16'h7FFF}};
        exp = '{1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 3; i++) begin
            mgmt_wr_i = wr[i];
            cyc(1);
            mgmt_wr_i = '0;
            cyc(2);
            `CHK("soft_busy", exp[i], phy_busy_o)
            `CHK("soft_nonphy", 1'b0, rst_vec_o.non_phy)
            `CHK("soft_strap", 4'hA, strap_o)
            if (exp[i]) wait_hi("soft_done", rst_done_o, DONE);
            cyc(10);
        end
        $display("test soft done");
    endtask
    task automatic t_link;
        int drops;
        int clears;
        for (int w = 0; w < 2; w++) begin
            wake_switch_i = w[0];
            link_rst_pin_n_i = 1'b0;
            drops = 0;
            repeat (10) begin
                cyc(1);
                drops += (pkt_drop_o === 1'b1);
            end
            `CHK("drop_once", 1, drops)
            `CHK("serdes_off", 8'h81, rst_vec_o & 8'h81)
            `CHK("phy_kept", 1'b0, phy_busy_o)
            link_rst_pin_n_i = 1'b1;
            clears = 0;
            repeat (10) begin
                cyc(1);
                clears += (rst_vec_o.fifo === 1'b1);
            end
            `CHK("fifo_clear", 1 - w, clears)
        end
        wake_switch_i = 1'b0;
        $display("test link done");
    endtask
    task automatic t_lan_off;
        lan_off_pin_n_i = 1'b0;
        cyc(8);
        `CHK("lan_off_phy", 1'b1, phy_busy_o)
        `CHK("pd_on", 1'b1, power_down_o)
        lan_off_pin_n_i = 1'b1;
        wait_hi("lan_off_done", rst_done_o, DONE);
        `CHK("pd_off", 1'b0, power_down_o)
        cyc(20);
        $display("test lan_off done");
    endtask
    task automatic t_inband;
        slow = 1'b1;
        inband_rst_i = 1'b1;
        cyc(1);
        inband_rst_i = 1'b0;
        wait_vec("ib_vec", 8'hF0, 3);
        `CHK("ib_strap", 4'hA, strap_o)
        `CHK("ib_pd", 1'b0, power_down_o)
        wait_hi("ib_done", rst_done_o, DONE);
        cyc(20);
        slow = 1'b0;
        $display("test inband done");
    endtask
    task automatic t_negotiate;
        int n;
        n = 0;
        cable_connect_i = 1'b1;
        while (negotiate_start_o !== 1'b1 && n < NMAX + 10) begin
            cyc(1);
            n++;
        end
        `CHK("neg_early", 1'b1, n >= NMIN - 1)
        `CHK("neg_late", 1'b1, n <= NMAX + 1)
        cable_connect_i = 1'b0;
        cyc(5);
        $display("test negotiate done");
    endtask
    task automatic t_supply_drop;
        supply_ok_i = 1'b0;
        xtal_ok_i = 1'b0;
        cyc(8);
        `CHK("drop_master", 1'b0, master_rst_n_o)
        `CHK("drop_vec", prc_pkg::RST_VEC_ALL, rst_vec_o)
        supply_ok_i = 1'b1;
        cyc(130);
        `CHK("xtal_late_set", 1'b1, xtal_late_o)
        xtal_ok_i = 1'b1;
        wait_hi("master_again", master_rst_n_o, 10);
        wait_hi("done_again", rst_done_o, DONE);
        $display("test supply_drop done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        bad_count++;
        $display("[FAIL] watchdog exp finish got hang");
        complete_run;
    end
    initial begin
        cyc(20);
        sys_rst_i = 1'b0;
        t_power_up;
        t_soft;
        t_link;
        t_lan_off;
        t_inband;
        t_negotiate;
        t_supply_drop;
        complete_run;
    end
endmodule
